// >>> include/tdcebf_pkg.sv
package tdcebf_pkg;
    // Register offsets (byte addresses on the 16-bit register port)
    localparam logic [15:0] OFS_BUF_LO = 16'h0000;
    localparam logic [15:0] OFS_BUF_HI = 16'h0ffc;
    localparam logic [15:0] OFS_SLOT = 16'h1002;
    localparam logic [15:0] OFS_CHAIN_ADDR = 16'h1004;
    localparam logic [15:0] OFS_BITS_SET = 16'h1006;
    localparam logic [15:0] OFS_BITS_CLR = 16'h1008;
    localparam logic [15:0] OFS_IRQ_LEVEL = 16'h100a;
    localparam logic [15:0] OFS_IRQ_VECTOR = 16'h100c;
    // Reset values
    localparam logic [7:0] CHAIN_ADDR_RST = 8'haa;
    localparam logic [4:0] SLOT_RST = 5'h1f;
    localparam logic [2:0] IRQ_LEVEL_RST = 3'h0;
    localparam logic [7:0] IRQ_VECTOR_RST = 8'h00;
    // Control bit positions
    localparam int BIT_BUS_ERR = 3;
    localparam int BIT_SEL_ADDR = 4;
    localparam int BIT_SOFT_RST = 7;
    localparam logic [15:0] CTRL_MASK = 16'h0098;
    // Second set register bits that admit suppressed data
    localparam int KEEP_OVER_BIT = 3;
    localparam int KEEP_UNDER_BIT = 4;
    localparam int KEEP_INVALID_BIT = 5;
    // Word layout
    localparam int SLOT_LSB = 27;
    localparam int TYPE_LSB = 24;
    localparam int CRATE_LSB = 16;
    localparam int COUNT_LSB = 8;
    localparam int CHAN_LSB = 16;
    localparam int VALID_BIT = 14;
    localparam int UNDER_BIT = 13;
    localparam int OVER_BIT = 12;
    localparam logic [2:0] TYPE_HEADER = 3'h2;
    localparam logic [2:0] TYPE_DATA = 3'h0;
    localparam logic [2:0] TYPE_TRAILER = 3'h4;
    localparam logic [2:0] TYPE_NOT_VALID = 3'h6;
    localparam logic [31:0] NOT_VALID_WORD = 32'h0600_0000;
endpackage

// >>> design/tdcebf_core.sv
// Contract
// - Header: slot 31..27, type 010, crate 23..16, stored channel count 13..8.
// - Data word: slot, type 000, channel 20..16, or 20..17 on 16 channels.
// - Bit 14 marks valid; invalid stored only when second-set bit 5 is one.
// - Bit 13 marks below threshold; stored only when second-set bit 4 is one.
// - Bit 12 marks overflow; stored only when second-set bit 3 is one.
// - Converted 12-bit value sits in bits 11..0 of data words.
// - Trailer closes event: slot, type 100, 24-bit event count in 23..0.
// - Type codes: 010 header, 000 data, 100 trailer, 110 not-valid.
// - Reading an empty buffer returns a not-valid word.
// - Channels stored interleaved 0,16,1,17..; suppressed ones omitted.
// - Slot register reloads on reset from backplane lines with auxiliary connector, else from the written value; default all ones.
// - With auxiliary connector, slot register writes get no acknowledge.
// - Broadcast/chain address register resets to 0xaa.
// - Set register write sets ones, leaves zeros; read returns state.
// - Clear register write clears ones, leaves zeros; read returns state.
// - Software-reset bit holds module in reset until cleared.
// - Hardware reset clears set register; software reset clears only bus-error.
// - Base address from rotary switch when select bit zero, else decoder.
// - Bus-error flag set at block-transfer bus error; software may set it.
// - Interrupt level in three low bits, default zero; zero disables.
// - Eight-bit vector, default zero, driven during interrupt acknowledge.
`timescale 1ns/1ps
module tdcebf_core
    import tdcebf_pkg::*;
#(
    parameter int NUM_CH = 32,
    parameter int DEPTH = 64,
    parameter bit HAS_AUX = 1'b1
)(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic reg_req_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic reg_ack_o,
    output logic [31:0] reg_rdata_o,
    // Conversion front end
    input wire logic conv_strobe_i,
    input wire logic [4:0] conv_chan_i,
    input wire logic [11:0] conv_value_i,
    input wire logic conv_valid_i,
    input wire logic conv_under_i,
    input wire logic conv_over_i,
    input wire logic evt_end_i,
    input wire logic [23:0] evt_count_i,
    output logic evt_ready_o,
    // Neighbouring register state
    input wire logic [7:0] crate_number_i,
    input wire logic [15:0] bits_set2_i,
    input wire logic bus_error_evt_i,
    // Addressing
    input wire logic [4:0] slot_lines_i,
    input wire logic [7:0] rotary_addr_i,
    input wire logic [15:0] decoder_addr_i,
    output logic [15:0] base_addr_o,
    output logic [7:0] chain_addr_o,
    output logic [4:0] slot_position_o,
    // Reset and interrupt
    output logic held_software_reset_o,
    input wire logic iack_i,
    output logic [7:0] iack_vector_o,
    output logic iack_drive_o,
    output logic [2:0] irq_level_o,
    output logic irq_enable_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int HALF = NUM_CH / 2;
    localparam int IW = $clog2(NUM_CH);
    localparam logic [2:0] SLOT_WAIT = 3'h4; // Edges until the slot register reloads from the settled pipe values

    typedef enum logic [1:0] {ST_COLLECT, ST_HEADER, ST_DATA, ST_TRAILER} tdceb_st_t;

    typedef struct packed {
        tdceb_st_t st;
        logic [NUM_CH-1:0] hit;
        logic [NUM_CH-1:0][14:0] conv;
        logic [IW-1:0] idx;
        logic [23:0] count;
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
        logic [2:0] slot_sync;
        logic [2:0][4:0] slot_pipe;
        logic [4:0] slot;
        logic [4:0] slot_pending;
        logic [2:0] reload;
        logic [7:0] chain_addr;
        logic [15:0] ctrl;
        logic [2:0] irq_level;
        logic [7:0] irq_vector;
        logic ack;
        logic [31:0] rdata;
    } tdceb_state_t;

    tdceb_state_t cur_ff;
    tdceb_state_t nxt_cur;
    logic [31:0] mem_ff [DEPTH];
    logic mem_we;
    logic [31:0] mem_wdata;

    // Filter per channel; each suppression class has its own admit bit
    logic [NUM_CH-1:0] kept;
    logic [6:0] kept_count;
    always_comb
    begin
        kept_count = 7'h00;
        for (int c = 0; c < NUM_CH; c++)
        begin
            kept[c] = cur_ff.hit[c]
                && (cur_ff.conv[c][14] || bits_set2_i[KEEP_INVALID_BIT])
                && (!cur_ff.conv[c][13] || bits_set2_i[KEEP_UNDER_BIT])
                && (!cur_ff.conv[c][12] || bits_set2_i[KEEP_OVER_BIT]);
            kept_count = kept_count + {6'h00, kept[c]};
        end
    end

    // Interleave order: even walk steps take low half, odd steps high half
    logic [IW-1:0] walk_chan;
    assign walk_chan = cur_ff.idx[0] ? (IW'(HALF) + {1'b0, cur_ff.idx[IW-1:1]})
                                     : {1'b0, cur_ff.idx[IW-1:1]};

    logic [4:0] chan_field;
    assign chan_field = (NUM_CH == 16) ? {walk_chan[3:0], 1'b0} : 5'(walk_chan);

    logic soft_rst;
    logic full;
    logic empty;
    logic buf_hit;
    logic rd_pop;
    assign soft_rst = cur_ff.ctrl[BIT_SOFT_RST];
    assign full = (cur_ff.wr_ptr[AW] != cur_ff.rd_ptr[AW])
        && (cur_ff.wr_ptr[AW-1:0] == cur_ff.rd_ptr[AW-1:0]);
    assign empty = cur_ff.wr_ptr == cur_ff.rd_ptr;
    assign buf_hit = reg_addr_i >= OFS_BUF_LO && reg_addr_i <= OFS_BUF_HI;
    assign rd_pop = reg_req_i && !reg_wr_i && buf_hit && !empty;

    // Next-state logic
    always_comb
    begin
        nxt_cur = cur_ff;
        mem_we = 1'b0;
        mem_wdata = 32'h0000_0000;
        nxt_cur.ack = 1'b0;

        // Slot lines: three stages, a change counts when the last two agree
        nxt_cur.slot_pipe[0] = slot_lines_i;
        nxt_cur.slot_pipe[1] = cur_ff.slot_pipe[0];
        nxt_cur.slot_pipe[2] = cur_ff.slot_pipe[1];
        // Pipe is cleared by reset, so wait until it carries settled pin values
        if (cur_ff.reload != 3'h0)
            nxt_cur.reload = cur_ff.reload - 3'h1;
        if (cur_ff.reload == 3'h1 || soft_rst)
        begin
            // Reload after hardware reset release and during software reset
            if (HAS_AUX && cur_ff.slot_pipe[1] == cur_ff.slot_pipe[2])
                nxt_cur.slot = cur_ff.slot_pipe[2];
            else if (!HAS_AUX)
                nxt_cur.slot = cur_ff.slot_pending;
        end

        // Event formatter
        case (cur_ff.st)
            ST_COLLECT:
            begin
                if (conv_strobe_i && 32'(conv_chan_i) < NUM_CH)
                begin
                    nxt_cur.hit[conv_chan_i[IW-1:0]] = 1'b1;
                    nxt_cur.conv[conv_chan_i[IW-1:0]] =
                        {conv_valid_i, conv_under_i, conv_over_i, conv_value_i};
                end
                if (evt_end_i)
                begin
                    nxt_cur.count = evt_count_i;
                    nxt_cur.idx = '0;
                    nxt_cur.st = ST_HEADER;
                end
            end
            ST_HEADER:
            begin
                if (!full)
                begin
                    mem_we = 1'b1;
                    mem_wdata = {cur_ff.slot, TYPE_HEADER, crate_number_i, 2'b00,
                        kept_count[5:0], 8'h00};
                    nxt_cur.st = ST_DATA;
                end
            end
            ST_DATA:
            begin
                if (!kept[walk_chan] || !full)
                begin
                    if (kept[walk_chan])
                    begin
                        mem_we = 1'b1;
                        mem_wdata = {cur_ff.slot, TYPE_DATA, 3'h0, chan_field, 1'b0,
                            cur_ff.conv[walk_chan]};
                    end
                    nxt_cur.idx = cur_ff.idx + IW'(1);
                    if (32'(cur_ff.idx) == NUM_CH - 1)
                        nxt_cur.st = ST_TRAILER;
                end
            end
            ST_TRAILER:
            begin
                if (!full)
                begin
                    mem_we = 1'b1;
                    mem_wdata = {cur_ff.slot, TYPE_TRAILER, cur_ff.count};
                    nxt_cur.hit = '0;
                    nxt_cur.st = ST_COLLECT;
                end
            end
            default:
            begin
                nxt_cur.st = ST_COLLECT;
            end
        endcase
        if (mem_we)
            nxt_cur.wr_ptr = cur_ff.wr_ptr + (AW+1)'(1);

        // Register port; answer one cycle after the request
        if (reg_req_i)
        begin
            nxt_cur.ack = 1'b1;
            nxt_cur.rdata = 32'h0000_0000;
            if (buf_hit && !reg_wr_i)
            begin
                nxt_cur.rdata = empty ? NOT_VALID_WORD
                                      : mem_ff[cur_ff.rd_ptr[AW-1:0]];
                if (!empty)
                    nxt_cur.rd_ptr = cur_ff.rd_ptr + (AW+1)'(1);
            end
            else
            begin
                case (reg_addr_i)
                    OFS_SLOT:
                    begin
                        nxt_cur.rdata = {27'h0, cur_ff.slot};
                        if (reg_wr_i && HAS_AUX)
                            nxt_cur.ack = 1'b0;
                        else if (reg_wr_i)
                            nxt_cur.slot_pending = reg_wdata_i[4:0];
                    end
                    OFS_CHAIN_ADDR:
                    begin
                        nxt_cur.rdata = {24'h0, cur_ff.chain_addr};
                        if (reg_wr_i)
                            nxt_cur.chain_addr = reg_wdata_i[7:0];
                    end
                    OFS_BITS_SET, OFS_BITS_CLR:
                    begin
                        nxt_cur.rdata = {16'h0, cur_ff.ctrl};
                        if (reg_wr_i && reg_addr_i == OFS_BITS_SET)
                            nxt_cur.ctrl = cur_ff.ctrl | (reg_wdata_i & CTRL_MASK);
                        else if (reg_wr_i)
                            nxt_cur.ctrl = cur_ff.ctrl & ~(reg_wdata_i & CTRL_MASK);
                    end
                    OFS_IRQ_LEVEL:
                    begin
                        nxt_cur.rdata = {29'h0, cur_ff.irq_level};
                        if (reg_wr_i)
                            nxt_cur.irq_level = reg_wdata_i[2:0];
                    end
                    OFS_IRQ_VECTOR:
                    begin
                        nxt_cur.rdata = {24'h0, cur_ff.irq_vector};
                        if (reg_wr_i)
                            nxt_cur.irq_vector = reg_wdata_i[7:0];
                    end
                    default:
                    begin
                        nxt_cur.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // Held software reset empties buffer and drops the event in flight
        if (soft_rst)
        begin
            nxt_cur.ctrl[BIT_BUS_ERR] = 1'b0;
            nxt_cur.wr_ptr = '0;
            nxt_cur.rd_ptr = '0;
            nxt_cur.hit = '0;
            nxt_cur.st = ST_COLLECT;
        end
        // Hardware event wins over any clear in the same cycle
        if (bus_error_evt_i)
            nxt_cur.ctrl[BIT_BUS_ERR] = 1'b1;
    end

    // State register; slot and pending both default to all ones
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cur_ff <= '0;
            cur_ff.st <= ST_COLLECT;
            cur_ff.slot <= SLOT_RST;
            cur_ff.slot_pending <= SLOT_RST;
            cur_ff.reload <= SLOT_WAIT;
            cur_ff.chain_addr <= CHAIN_ADDR_RST;
            cur_ff.ctrl <= 16'h0000;
            cur_ff.irq_level <= IRQ_LEVEL_RST;
            cur_ff.irq_vector <= IRQ_VECTOR_RST;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // Buffer storage has no reset; pointers guard its contents
    always_ff @(posedge sys_clk_i)
    begin
        if (mem_we && !soft_rst)
            mem_ff[cur_ff.wr_ptr[AW-1:0]] <= mem_wdata;
    end

    // Outputs
    assign reg_ack_o = cur_ff.ack;
    assign reg_rdata_o = cur_ff.rdata;
    assign evt_ready_o = cur_ff.st == ST_COLLECT && !soft_rst;
    assign base_addr_o = cur_ff.ctrl[BIT_SEL_ADDR] ? decoder_addr_i
                                                   : {rotary_addr_i, 8'h00};
    assign chain_addr_o = cur_ff.chain_addr;
    assign slot_position_o = cur_ff.slot;
    assign held_software_reset_o = soft_rst;
    assign irq_level_o = cur_ff.irq_level;
    assign irq_enable_o = cur_ff.irq_level != 3'h0;
    assign iack_drive_o = iack_i && irq_enable_o;
    assign iack_vector_o = cur_ff.irq_vector;

    // Checks
    sequence set_write_s;
        reg_req_i && reg_wr_i && reg_addr_i == OFS_BITS_SET;
    endsequence

    ctrl_set_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (set_write_s and !reg_wdata_i[BIT_SEL_ADDR]) |=> cur_ff.ctrl[BIT_SEL_ADDR]
            == $past(cur_ff.ctrl[BIT_SEL_ADDR]))
        else $error("set write altered a bit written as zero");
    ctrl_clear_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        reg_req_i && reg_wr_i && reg_addr_i == OFS_BITS_CLR && reg_wdata_i[BIT_SEL_ADDR]
            |=> !cur_ff.ctrl[BIT_SEL_ADDR])
        else $error("clear write left select bit set");
    bus_err_set_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        bus_error_evt_i |=> cur_ff.ctrl[BIT_BUS_ERR])
        else $error("bus error event lost");
    empty_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        reg_req_i && !reg_wr_i && buf_hit && empty |=> reg_ack_o
            && reg_rdata_o == NOT_VALID_WORD)
        else $error("empty buffer read not answered with not-valid word");
    slot_nack_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        HAS_AUX && reg_req_i && reg_wr_i && reg_addr_i == OFS_SLOT |=> !reg_ack_o)
        else $error("slot write acknowledged with auxiliary connector");
    header_type_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        cur_ff.st == ST_HEADER && mem_we |-> mem_wdata[26:24] == TYPE_HEADER
            && mem_wdata[13:8] == kept_count[5:0] ##1 cur_ff.st == ST_DATA)
        else $error("header word badly formed");
    trailer_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        cur_ff.st == ST_TRAILER && mem_we |-> mem_wdata[23:0] == cur_ff.count
            && mem_wdata[31:27] == cur_ff.slot)
        else $error("trailer word badly formed");
    data_kept_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        cur_ff.st == ST_DATA && mem_we && !bits_set2_i[KEEP_INVALID_BIT]
            |-> mem_wdata[VALID_BIT])
        else $error("invalid datum stored while not admitted");
    irq_off_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        cur_ff.irq_level == 3'h0 |-> !irq_enable_o && !iack_drive_o)
        else $error("interrupt active at level zero");
endmodule

// >>> verif/tdcebf_host.sv
`timescale 1ns/1ps
module tdcebf_host (
    // Clock
    input wire logic sys_clk_i,
    // Answer from the block
    input wire logic ack_i,
    // Request to the block
    output logic req_o,
    output logic wr_o,
    output logic [15:0] addr_o,
    output logic [15:0] wdata_o
);
    // Idle lines carry junk so a stale value never looks like a request
    initial
    begin
        req_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 16'h5a5a;
        wdata_o = 16'ha5a5;
    end

    // Pulse the request, hold its qualifiers until the answer edge
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                       output logic ack);
        @(posedge sys_clk_i);
        req_o <= 1'b1;
        wr_o <= w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge sys_clk_i);
        req_o <= 1'b0;
        @(posedge sys_clk_i);
        ack = ack_i;
        // Released lines invert so nothing relies on a held value
        wr_o <= ~w;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
endmodule

// >>> verif/tdcebf_core_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) \
    begin checks_done++; if ((s) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, s); end end
module tdcebf_core_bench;
    import tdcebf_pkg::*;
    logic sys_clk_i, resetn_i, reg_req_i, reg_wr_i, reg_ack_o, evt_ready_o;
    logic [15:0] reg_addr_i, reg_wdata_i, bits_set2_i, decoder_addr_i, base_addr_o;
    logic [31:0] reg_rdata_o, exp_v;
    logic conv_strobe_i, conv_valid_i, conv_under_i, conv_over_i, evt_end_i;
    logic [4:0] conv_chan_i, slot_lines_i, slot_position_o, slot_exp;
    logic [11:0] conv_value_i;
    logic [23:0] evt_count_i;
    logic [7:0] crate_number_i, rotary_addr_i, chain_addr_o, iack_vector_o, ca;
    logic bus_error_evt_i, held_software_reset_o, iack_i, iack_drive_o, irq_enable_o;
    logic [2:0] irq_level_o;
    logic rd_d = 1'b0;
    logic ak;
    logic [31:0] exp_q [$];
    int n_fail = 0;
    int checks_done = 0;

    tdcebf_core #(.NUM_CH(32), .DEPTH(64), .HAS_AUX(1'b1)) tdcebf_core_inst (
        .sys_clk_i, .resetn_i, .reg_req_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
        .reg_ack_o, .reg_rdata_o, .conv_strobe_i, .conv_chan_i, .conv_value_i,
        .conv_valid_i, .conv_under_i, .conv_over_i, .evt_end_i, .evt_count_i,
        .evt_ready_o, .crate_number_i, .bits_set2_i, .bus_error_evt_i,
        .slot_lines_i, .rotary_addr_i, .decoder_addr_i, .base_addr_o,
        .chain_addr_o, .slot_position_o, .held_software_reset_o, .iack_i,
        .iack_vector_o, .iack_drive_o, .irq_level_o, .irq_enable_o);

    tdcebf_host tdcebf_host_inst (.sys_clk_i(sys_clk_i), .ack_i(reg_ack_o),
        .req_o(reg_req_i), .wr_o(reg_wr_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));

    // Clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // Read answers come one cycle after a taken read; match oldest note
    always @(posedge sys_clk_i)
    begin
        if (reg_ack_o === 1'b1 && rd_d === 1'b1)
        begin
            exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 32'hdead_beef;
            `CHK("read data", exp_v, reg_rdata_o)
        end
        rd_d <= reg_req_i & ~reg_wr_i;
    end

    // Reads note their expectation first; writes must be answered
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        tdcebf_host_inst.acc(1'b0, a, 16'h0000, ak);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        tdcebf_host_inst.acc(1'b1, a, d, ak);
        `CHK("write ack", 1'b1, ak)
    endtask

    // One event of random conversions, closed, then read back in store order
    task automatic run_event(input logic [2:0] keep);
        logic [31:0] dw [32];
        logic hit [32];
        logic [31:0] r;
        logic [5:0] n;
        logic [23:0] cnt;
        int c;
        n = 6'h00;
        cnt = 24'($urandom());
        bits_set2_i <= {10'h000, keep, 3'h0};
        for (int i = 0; i < 32; i++)
        begin
            r = $urandom();
            hit[i] = (r[15] | &keep) & (r[12] | keep[2]) & (~r[13] | keep[1])
                & (~r[14] | keep[0]);
            dw[i] = {slot_exp, 6'h00, 5'(i), 1'b0, r[14:12], r[11:0]};
            n = n + 6'(hit[i]);
            conv_strobe_i <= r[15] | &keep;
            conv_chan_i <= 5'(i);
            conv_value_i <= r[11:0];
            conv_valid_i <= r[14];
            conv_under_i <= r[13];
            conv_over_i <= r[12];
            dw[i][14:12] = {r[14], r[13], r[12]};
            hit[i] = (r[15] | &keep) & (r[14] | keep[2]) & (~r[13] | keep[1])
                & (~r[12] | keep[0]);
            n = n - 6'((r[15] | &keep) & (r[12] | keep[2]) & (~r[13] | keep[1])
                & (~r[14] | keep[0])) + 6'(0);
            @(posedge sys_clk_i);
        end
        n = 6'h00;
        for (int i = 0; i < 32; i++)
            n = n + 6'(hit[i]);
        conv_strobe_i <= 1'b0;
        evt_end_i <= 1'b1;
        evt_count_i <= cnt;
        @(posedge sys_clk_i);
        evt_end_i <= 1'b0;
        c = 0;
        repeat (2) @(posedge sys_clk_i);
        while (evt_ready_o !== 1'b1 && c < 200)
        begin
            @(posedge sys_clk_i);
            c++;
        end
        `CHK("event done", 1'b1, evt_ready_o)
        rd(OFS_BUF_LO, {slot_exp, 3'b010, crate_number_i, 2'b00, n, 8'h00});
        for (int k = 0; k < 32; k++)
        begin
            c = k / 2 + (k % 2) * 16;
            if (hit[c])
                rd(OFS_BUF_LO, dw[c]);
        end
        rd(OFS_BUF_HI, {slot_exp, 3'b100, cnt});
        rd(OFS_BUF_LO, {5'h00, 3'b110, 24'h000000});
    endtask

    // Verdict
    task automatic end_sim();
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (30000) @(posedge sys_clk_i);
        n_fail++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        void'($urandom(28));
        resetn_i = 1'b0;
        {conv_strobe_i, conv_valid_i, conv_under_i, conv_over_i} = 4'h0;
        {evt_end_i, bus_error_evt_i, iack_i} = 3'h0;
        conv_chan_i = 5'h00;
        conv_value_i = 12'h000;
        evt_count_i = 24'h000000;
        bits_set2_i = 16'h0000;
        crate_number_i = 8'($urandom());
        slot_lines_i = 5'($urandom());
        slot_exp = slot_lines_i;
        rotary_addr_i = 8'($urandom());
        decoder_addr_i = 16'($urandom());
        repeat (6) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        // Slot pins need the synchroniser filled before the reload lands
        repeat (4) @(posedge sys_clk_i);
        rd(OFS_SLOT, 32'(slot_exp));
        `CHK("slot pos", slot_exp, slot_position_o)
        rd(OFS_CHAIN_ADDR, 32'h0000_00aa);
        rd(OFS_BITS_SET, 32'h0000_0000);
        rd(OFS_IRQ_LEVEL, 32'h0000_0000);
        rd(OFS_IRQ_VECTOR, 32'h0000_0000);
        rd(OFS_BUF_LO, {5'h00, 3'b110, 24'h000000});
        rd(16'h2000, 32'h0000_0000);
        `CHK("base rotary", {rotary_addr_i, 8'h00}, base_addr_o)
        wr(OFS_BITS_SET, 16'h0010);
        `CHK("base decoder", decoder_addr_i, base_addr_o)
        wr(OFS_BITS_SET, 16'h0008);
        rd(OFS_BITS_SET, 32'h0000_0018);
        wr(OFS_BITS_CLR, 16'h0008);
        rd(OFS_BITS_CLR, 32'h0000_0010);
        @(posedge sys_clk_i);
        bus_error_evt_i <= 1'b1;
        @(posedge sys_clk_i);
        bus_error_evt_i <= 1'b0;
        rd(OFS_BITS_SET, 32'h0000_0018);
        wr(OFS_BITS_CLR, 16'h0018);
        `CHK("base back", {rotary_addr_i, 8'h00}, base_addr_o)
        // Every interrupt level, including the disabling zero
        for (int lv = 0; lv < 8; lv++)
        begin
            ca = 8'($urandom());
            wr(OFS_IRQ_LEVEL, 16'(lv));
            wr(OFS_IRQ_VECTOR, {8'h00, ca});
            rd(OFS_IRQ_LEVEL, 32'(lv));
            rd(OFS_IRQ_VECTOR, 32'(ca));
            iack_i <= 1'b1;
            @(posedge sys_clk_i);
            `CHK("irq level", 3'(lv), irq_level_o)
            `CHK("irq enable", lv != 0, irq_enable_o)
            `CHK("iack drive", lv != 0, iack_drive_o)
            `CHK("iack vector", ca, iack_vector_o)
            iack_i <= 1'b0;
        end
        ca = 8'($urandom());
        wr(OFS_CHAIN_ADDR, {8'h00, ca});
        rd(OFS_CHAIN_ADDR, 32'(ca));
        `CHK("chain addr", ca, chain_addr_o)
        // Random admission settings, last one admits everything
        for (int e = 0; e < 4; e++)
        begin
            crate_number_i <= 8'($urandom());
            run_event(e == 3 ? 3'h7 : 3'($urandom()));
        end
        tdcebf_host_inst.acc(1'b1, OFS_SLOT, 16'h0003, ak);
        `CHK("slot write ack", 1'b0, ak)
        slot_exp = ~slot_exp;
        slot_lines_i <= slot_exp;
        // Reset after the slot write so the backplane value is taken again
        wr(OFS_BITS_SET, 16'h0088);
        repeat (6) @(posedge sys_clk_i);
        `CHK("held reset", 1'b1, held_software_reset_o)
        rd(OFS_BITS_SET, 32'h0000_0080);
        wr(OFS_BITS_CLR, 16'h0080);
        `CHK("held released", 1'b0, held_software_reset_o)
        rd(OFS_SLOT, 32'(slot_exp));
        `CHK("slot held", slot_exp, slot_position_o)
        wr(OFS_BITS_SET, 16'h0010);
        resetn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd(OFS_CHAIN_ADDR, 32'h0000_00aa);
        rd(OFS_BITS_SET, 32'h0000_0000);
        repeat (4) @(posedge sys_clk_i);
        `CHK("slot after reset", slot_exp, slot_position_o)
        end_sim();
    end
endmodule
